// *** design/tms_top.v ***
`include "tms_defines.vh"

module tms_top #(
  parameter NG        = 4,
  parameter GW        = 4,
  parameter IW        = 16,
  parameter P_MS_CYC  = `TMS_CLK_KHZ,
  parameter P_RST_MS  = `TMS_RESET_MS,
  parameter P_LOCK_MS = `TMS_LOCK_MS
) (
  input  wire            i_clk,
  input  wire            i_rst_n,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [7:0]      paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output wire            pready,
  output wire            pslverr,
  input  wire            i_simulator_lock_a,
  input  wire            i_simulator_lock_b,
  input  wire            i_external_post_fault_jump,
  input  wire            i_external_sim_trigger,
  input  wire [IW-1:0]   i_ia,
  input  wire [IW-1:0]   i_ib,
  input  wire [IW-1:0]   i_ic,
  input  wire            i_protection_trip_order,
  output reg             o_protection_trip_order,
  input  wire [NG*GW-1:0] i_contact_drive,
  input  wire [NG*GW-1:0] i_contact_latched,
  input  wire [NG*GW-1:0] i_contact_hold_run,
  input  wire [NG*GW-1:0] i_single_output_override_en,
  input  wire [NG*GW-1:0] i_single_output_override_val,
  output reg  [NG*GW-1:0] o_contact,
  input  wire            i_zone_il_drive,
  input  wire            i_supv_drive,
  output reg             o_zone_il,
  output reg             o_supv,
  output reg  [2:0]      o_phase_code,
  output reg             o_prot_inhibit,
  output reg             o_energy_halt,
  output reg             o_sim_active,
  input  wire [2:0]      i_sim_ch,
  output reg  [31:0]     o_sim_value,
  output reg             o_sim_volt_pn,
  output reg  [19:0]     o_sim_freq_mhz
);

  localparam NC = NG * GW;
  // sequencer states
  localparam S_IDLE = 3'h0;
  localparam S_RST1 = 3'h1;
  localparam S_PRE  = 3'h2;
  localparam S_FLT  = 3'h3;
  localparam S_POST = 3'h4;
  localparam S_RST2 = 3'h5;

  // recorder code for a state
  function [2:0] tms_code;
    input [2:0] st;
    begin
      case (st)
        S_IDLE: tms_code = `TMS_PC_NORM;
        S_PRE:  tms_code = `TMS_PC_PRE;
        S_FLT:  tms_code = `TMS_PC_FLT;
        S_POST: tms_code = `TMS_PC_POST;
        default: tms_code = `TMS_PC_RST;
      endcase
    end
  endfunction

  reg  [`TMS_CTRL_W-1:0] ctrl_reg;
  reg  [NG-1:0]          dgrp_reg;
  reg  [15:0]            dtime_reg;
  reg  [15:0]            tpre_reg;
  reg  [15:0]            tflt_reg;
  reg  [15:0]            tpost_reg;
  reg  [IW-1:0]          ratedi_reg;
  reg  [19:0]            ratedf_reg;
  reg  [31:0]            sim_mem [0:`TMS_SIM_WORDS-1];
  reg  [2:0]             state_reg;
  reg  [2:0]             state_next;
  reg  [15:0]            ptmr_reg;
  reg  [15:0]            ptmr_next;
  reg  [31:0]            ms_cnt_reg;
  reg                    ms_tick_reg;
  reg                    lock_reg;
  reg  [15:0]            lock_cnt_reg;
  reg                    jump_d_reg;
  reg                    trig_d_reg;
  reg  [NG-1:0]          dreq_reg;
  reg  [NC-1:0]          dis_reg;
  reg  [NC-1:0]          dis_next;
  reg  [31:0]            rd_data;
  reg                    rd_ok;

  // either lock input blocks; declared early for the status read
  wire blocked = i_simulator_lock_a | i_simulator_lock_b;
  wire running = (state_reg != S_IDLE);
  // apb decode
  wire setup   = psel & ~penable;
  wire acc     = psel & penable;
  wire wr      = acc & pwrite;
  wire in_sim  = (paddr >= `TMS_A_SIM_LO) && (paddr <= `TMS_A_SIM_HI);
  wire [7:0] sim_off = paddr - `TMS_A_SIM_LO;
  wire [4:0] sim_widx = sim_off[6:2];
  wire cmd_wr  = wr && (paddr == `TMS_A_CMD);
  wire k_start = cmd_wr & pwdata[`TMS_K_START];
  wire k_stop  = cmd_wr & pwdata[`TMS_K_STOP];
  wire k_apply = cmd_wr & pwdata[`TMS_K_APPLY];
  wire k_rel   = cmd_wr & pwdata[`TMS_K_RELEASE];

  // zero wait states; only unmapped access errors
  assign pready  = 1'b1;
  assign pslverr = acc & ~rd_ok;

  // read mux and address check
  always @* begin
    rd_ok   = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      `TMS_A_CTRL:   rd_data[`TMS_CTRL_W-1:0] = ctrl_reg;
      `TMS_A_CMD:    rd_data = 32'h0000_0000;
      `TMS_A_DGRP:   rd_data[NG-1:0] = dgrp_reg;
      `TMS_A_DTIME:  rd_data[15:0] = dtime_reg;
      `TMS_A_TPRE:   rd_data[15:0] = tpre_reg;
      `TMS_A_TFLT:   rd_data[15:0] = tflt_reg;
      `TMS_A_TPOST:  rd_data[15:0] = tpost_reg;
      `TMS_A_RATEDI: rd_data[IW-1:0] = ratedi_reg;
      `TMS_A_RATEDF: rd_data[19:0] = ratedf_reg;
      `TMS_A_STATUS: rd_data = {16'h0000, {(8-NG){1'b0}}, dreq_reg,
                                2'b00, blocked, lock_reg,
                                running, tms_code(state_reg)};
      `TMS_A_DSTATE: rd_data[NC-1:0] = dis_reg;
      default: begin
        if (in_sim && (paddr[1:0] == 2'b00))
          rd_data = sim_mem[sim_widx];
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  // read data captured in setup so prdata comes from a flop
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rd_data;
  end

  // configuration registers, written at the access edge
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg   <= {`TMS_CTRL_W{1'b0}};
      dgrp_reg   <= {NG{1'b0}};
      dtime_reg  <= 16'h0000;
      tpre_reg   <= 16'h0000;
      tflt_reg   <= 16'h0000;
      tpost_reg  <= 16'h0000;
      ratedi_reg <= {IW{1'b0}};
      ratedf_reg <= 20'h00000;
    end else if (wr) begin
      case (paddr)
        `TMS_A_CTRL:   ctrl_reg   <= pwdata[`TMS_CTRL_W-1:0];
        `TMS_A_DGRP:   dgrp_reg   <= pwdata[NG-1:0];
        `TMS_A_DTIME:  dtime_reg  <= pwdata[15:0];
        `TMS_A_TPRE:   tpre_reg   <= pwdata[15:0];
        `TMS_A_TFLT:   tflt_reg   <= pwdata[15:0];
        `TMS_A_TPOST:  tpost_reg  <= pwdata[15:0];
        `TMS_A_RATEDI: ratedi_reg <= pwdata[IW-1:0];
        `TMS_A_RATEDF: ratedf_reg <= pwdata[19:0];
        default: ;
      endcase
    end
  end

  // simulated quantities table, no reset needed
  always @(posedge i_clk) begin
    if (wr && in_sim && (paddr[1:0] == 2'b00))
      sim_mem[sim_widx] <= pwdata;
  end

  // millisecond tick shared by all timers
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ms_cnt_reg  <= 32'h0000_0000;
      ms_tick_reg <= 1'b0;
    end else if (ms_cnt_reg == P_MS_CYC - 1) begin
      ms_cnt_reg  <= 32'h0000_0000;
      ms_tick_reg <= 1'b1;
    end else begin
      ms_cnt_reg  <= ms_cnt_reg + 32'h0000_0001;
      ms_tick_reg <= 1'b0;
    end
  end

  // any phase above rated / 10
  wire [IW+3:0] lim = {4'h0, ratedi_reg};
  wire over = ({4'h0, i_ia} * `TMS_OC_DIV > lim) |
              ({4'h0, i_ib} * `TMS_OC_DIV > lim) |
              ({4'h0, i_ic} * `TMS_OC_DIV > lim);
  wire trig_rise = ctrl_reg[`TMS_C_TRIG_EN] & i_external_sim_trigger &
                   ~trig_d_reg;
  wire jump_rise = ctrl_reg[`TMS_C_JUMP_EN] &
                   i_external_post_fault_jump & ~jump_d_reg;
  // starts ignored when blocked, locked out or running
  wire start_ok = (k_start | trig_rise) & ~blocked & ~lock_reg &
                  ~over & ~running;
  wire ph_done = ms_tick_reg && (ptmr_reg <= 16'h0001);

  // lockout stays until five seconds below threshold
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lock_reg     <= 1'b0;
      lock_cnt_reg <= 16'h0000;
    end else if (over) begin
      lock_cnt_reg <= 16'h0000;
      if (running)
        lock_reg <= 1'b1;
    end else if (lock_reg && ms_tick_reg) begin
      if (lock_cnt_reg == P_LOCK_MS - 1) begin
        lock_reg     <= 1'b0;
        lock_cnt_reg <= 16'h0000;
      end else begin
        lock_cnt_reg <= lock_cnt_reg + 16'h0001;
      end
    end
  end

  // sequencer next state
  always @* begin
    state_next = state_reg;
    ptmr_next  = ptmr_reg;
    if (ms_tick_reg && ptmr_reg != 16'h0000)
      ptmr_next = ptmr_reg - 16'h0001;
    case (state_reg)
      S_IDLE: begin
        if (start_ok) begin
          state_next = S_RST1;
          ptmr_next  = P_RST_MS[15:0];
        end
      end
      S_RST1: if (ph_done) begin
        state_next = S_PRE;
        ptmr_next  = tpre_reg;
      end
      S_PRE: begin
        if (jump_rise) begin
          state_next = S_POST;
          ptmr_next  = tpost_reg;
        end else if (ph_done) begin
          state_next = S_FLT;
          ptmr_next  = tflt_reg;
        end
      end
      S_FLT: begin
        if (jump_rise || ph_done) begin
          state_next = S_POST;
          ptmr_next  = tpost_reg;
        end
      end
      // full run closes here without jump
      S_POST: if (ph_done) begin
        state_next = S_RST2;
        ptmr_next  = P_RST_MS[15:0];
      end
      // back to normal after closing reset
      S_RST2: if (ph_done)
        state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
    if (running && (k_stop || over || blocked)) begin
      state_next = S_IDLE;
      ptmr_next  = 16'h0000;
    end
  end

  // sequencer registers and edge history
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg  <= S_IDLE;
      ptmr_reg   <= 16'h0000;
      jump_d_reg <= 1'b0;
      trig_d_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      ptmr_reg   <= ptmr_next;
      jump_d_reg <= i_external_post_fault_jump;
      trig_d_reg <= i_external_sim_trigger;
    end
  end

  // sequencer outputs, one cycle after the state
  wire sim_ph = (state_reg == S_PRE) | (state_reg == S_FLT) |
                (state_reg == S_POST);
  wire [1:0] ph_idx = (state_reg == S_PRE) ? 2'd0 :
                      (state_reg == S_FLT) ? 2'd1 : 2'd2;
  wire [4:0] rd_idx = {ph_idx, i_sim_ch};
  // rated * 1600 ppm, kept wide to avoid overflow
  wire [39:0] f_ofs = ({20'h00000, ratedf_reg} * `TMS_FREQ_PPM) /
                      `TMS_PPM_DEN;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_phase_code   <= `TMS_PC_NORM;
      o_prot_inhibit <= 1'b0;
      o_energy_halt  <= 1'b0;
      o_sim_active   <= 1'b0;
      o_sim_value    <= 32'h0000_0000;
      o_sim_volt_pn  <= 1'b0;
      o_sim_freq_mhz <= 20'h00000;
      o_protection_trip_order <= 1'b0;
    end else begin
      o_phase_code   <= tms_code(state_reg);
      // protection held inactive in reset phases
      o_prot_inhibit <= (state_reg == S_RST1) | (state_reg == S_RST2);
      o_energy_halt  <= running;
      o_sim_active   <= sim_ph;
      o_sim_value    <= sim_ph ? sim_mem[rd_idx] : 32'h0000_0000;
      o_sim_volt_pn  <= 1'b1;
      // simulated frequency raised by 0.16 percent
      o_sim_freq_mhz <= ratedf_reg + f_ofs[19:0];
      // cold mode blocks trip orders during a run
      o_protection_trip_order <= i_protection_trip_order &
                                 (~running | ctrl_reg[`TMS_C_HOT]);
    end
  end

  // disarm request per group with optional timeout
  genvar g;
  generate
    for (g = 0; g < NG; g = g + 1) begin : grp
      reg [15:0] dtmr_reg;
      wire set_g = k_apply & dgrp_reg[g] & ctrl_reg[`TMS_C_DIS_ACT];
      wire exp_g = ctrl_reg[`TMS_C_DIS_TMD] & ms_tick_reg &
                   (dtmr_reg <= 16'h0001);
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          dreq_reg[g] <= 1'b0;
          dtmr_reg    <= 16'h0000;
        end else if (set_g) begin
          // apply wins over a coincident expiry
          dreq_reg[g] <= 1'b1;
          dtmr_reg    <= dtime_reg;
        end else if (exp_g || k_rel || !ctrl_reg[`TMS_C_DIS_ACT]) begin
          dreq_reg[g] <= 1'b0;
          dtmr_reg    <= 16'h0000;
        end else if (ms_tick_reg && dtmr_reg != 16'h0000) begin
          dtmr_reg <= dtmr_reg - 16'h0001;
        end
      end
    end
  endgenerate

  // per-contact disarm state; c and k keep the two loops apart
  integer c, k;
  always @* begin
    dis_next = {NC{1'b0}};
    for (c = 0; c < NC; c = c + 1) begin
      // enter only unlatched, no hold timer, control active
      dis_next[c] = dreq_reg[c / GW] &
                    (dis_reg[c] | (~i_contact_latched[c] &
                     ~i_contact_hold_run[c] & ctrl_reg[`TMS_C_DIS_ACT]));
    end
  end

  // contact outputs
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dis_reg   <= {NC{1'b0}};
      o_contact <= {NC{1'b0}};
      o_zone_il <= 1'b0;
      o_supv    <= 1'b0;
    end else begin
      dis_reg <= dis_next;
      for (k = 0; k < NC; k = k + 1) begin
        if (!dis_reg[k])
          o_contact[k] <= i_single_output_override_en[k] ?
                          i_single_output_override_val[k] :
                          i_contact_drive[k];
      end
      o_zone_il <= i_zone_il_drive;
      o_supv    <= i_supv_drive;
    end
  end

endmodule

// *** pkg/tms_defines.vh ***
// Overview of operation
// - contact group disarm is permanent or timed; timed ends when timer expires
// - a disarmed contact group keeps each contact frozen once that contact enters disarm, no switching
// - zone interlock output and supervision contact are never disarmed
// - disarm entered only unlatched, no hold timer, control active, command applied
// - cycle runs reset 100 ms, pre-fault, fault, post-fault, reset again
// - protection functions held inactive during both reset phases
// - phase codes: 0 normal, 1 pre, 2 fault, 3 post, 4 reset
// - phase durations and simulated quantities set per phase and channel
// - any phase current above 0.1 rated aborts the run at once
// - after such abort, restart only after five seconds below threshold
// - either of two lock inputs blocks the simulator
// - jump signal in pre-fault or fault moves straight to post-fault
// - energy counters halted while the simulator runs
// - simulated voltages always phase-to-neutral quantities
// - simulated frequency is 0.16 percent above rated frequency
// - cold mode blocks trip orders during a run, hot mode passes them
// - manual start without jump assigned runs the full sequence
// - manual stop ends the run at once, back to normal
// - assigned external trigger starts unless locked or current lockout
// - a disarmed contact ignores any single override command
`ifndef TMS_DEFINES_VH
`define TMS_DEFINES_VH

// apb register byte offsets
`define TMS_A_CTRL     8'h00
`define TMS_A_CMD      8'h04
`define TMS_A_DGRP     8'h08
`define TMS_A_DTIME    8'h0c
`define TMS_A_TPRE     8'h10
`define TMS_A_TFLT     8'h14
`define TMS_A_TPOST    8'h18
`define TMS_A_RATEDI   8'h1c
`define TMS_A_RATEDF   8'h20
`define TMS_A_STATUS   8'h24
`define TMS_A_DSTATE   8'h28
`define TMS_A_SIM_LO   8'h40
`define TMS_A_SIM_HI   8'h9c

// ctrl bits
`define TMS_C_HOT      0
`define TMS_C_DIS_ACT  1
`define TMS_C_DIS_TMD  2
`define TMS_C_JUMP_EN  3
`define TMS_C_TRIG_EN  4
`define TMS_CTRL_W     5
// cmd bits (write one pulses)
`define TMS_K_START    0
`define TMS_K_STOP     1
`define TMS_K_APPLY    2
`define TMS_K_RELEASE  3

// phase codes seen by the recorders
`define TMS_PC_NORM    3'h0
`define TMS_PC_PRE     3'h1
`define TMS_PC_FLT     3'h2
`define TMS_PC_POST    3'h3
`define TMS_PC_RST     3'h4

// timing
`define TMS_CLK_KHZ    20000
`define TMS_RESET_MS   100
`define TMS_LOCK_MS    5000
// current threshold is rated / 10
`define TMS_OC_DIV     10
// frequency offset in parts per million
`define TMS_FREQ_PPM   1600
`define TMS_PPM_DEN    1000000
// simulation table: 8 channel words per phase
`define TMS_SIM_CH     8
`define TMS_SIM_WORDS  24

`endif

// *** verif/tms_top_sva.sv ***
module tms_sva_chk #(
  parameter P_MS_CYC = 4,
  parameter P_RST_MS = 3
) (
  input wire        i_clk,
  input wire        i_rst_n,
  input wire        i_simulator_lock_a,
  input wire        i_simulator_lock_b,
  input wire        i_protection_trip_order,
  input wire        o_protection_trip_order,
  input wire        i_zone_il_drive,
  input wire        i_supv_drive,
  input wire        o_zone_il,
  input wire        o_supv,
  input wire [2:0]  o_phase_code,
  input wire        o_prot_inhibit,
  input wire        o_energy_halt,
  input wire        o_sim_active,
  input wire [31:0] o_sim_value,
  input wire        o_sim_volt_pn
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // cycles spent in one reset phase; a stuck timer shows here
  reg [15:0] rst_cnt_reg;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      rst_cnt_reg <= 16'h0000;
    else if (o_phase_code == 3'h4)
      rst_cnt_reg <= rst_cnt_reg + 16'h0001;
    else
      rst_cnt_reg <= 16'h0000;
  end
  property p_rst_inhibit;
    o_phase_code == 3'h4 |-> o_prot_inhibit;
  endproperty
  a_rst_inhibit: assert property (p_rst_inhibit)
    else $error("protection not inhibited in reset phase");
  property p_halt_run;
    o_sim_active |-> o_energy_halt;
  endproperty
  a_halt_run: assert property (p_halt_run)
    else $error("energy counters run during simulation");
  property p_code_legal;
    o_phase_code <= 3'h4;
  endproperty
  a_code_legal: assert property (p_code_legal)
    else $error("phase code out of range");
  property p_active_code;
    o_sim_active == (o_phase_code != 3'h0 && o_phase_code != 3'h4);
  endproperty
  a_active_code: assert property (p_active_code)
    else $error("active flag disagrees with phase code");
  property p_excluded;
    $past(i_rst_n) |-> {o_zone_il, o_supv} ==
      $past({i_zone_il_drive, i_supv_drive});
  endproperty
  a_excluded: assert property (p_excluded)
    else $error("interlock or supervision output not following");
  property p_trip_pass;
    $past(i_rst_n) && $past(o_phase_code, 2) == 3'h0 &&
      $past(o_phase_code) == 3'h0 && o_phase_code == 3'h0
      |-> o_protection_trip_order == $past(i_protection_trip_order);
  endproperty
  a_trip_pass: assert property (p_trip_pass)
    else $error("trip order lost in normal operation");
  property p_lock_end;
    o_sim_active && (i_simulator_lock_a || i_simulator_lock_b)
      |-> ##2 o_phase_code == 3'h0;
  endproperty
  a_lock_end: assert property (p_lock_end)
    else $error("lock input did not end the run");
  property p_volt_pn;
    $past(i_rst_n) |-> o_sim_volt_pn;
  endproperty
  a_volt_pn: assert property (p_volt_pn)
    else $error("simulated voltage not phase to neutral");
  property p_rst_len;
    rst_cnt_reg <= P_RST_MS * P_MS_CYC + 2;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("reset phase too long");
  property p_idle_value;
    !o_sim_active && !$past(o_sim_active) |-> o_sim_value == 32'h0;
  endproperty
  a_idle_value: assert property (p_idle_value)
    else $error("simulated value outside a run");
  c_full_run: cover property (o_phase_code == 3'h3 ##1 o_phase_code == 3'h4);
  c_lock: cover property (o_sim_active && i_simulator_lock_b);
  c_trip_block: cover property (o_sim_active && !o_protection_trip_order
    && i_protection_trip_order);
endmodule

bind tms_top tms_sva_chk #(
  .P_MS_CYC(P_MS_CYC),
  .P_RST_MS(P_RST_MS)
) u_tms_sva_chk (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_simulator_lock_a(i_simulator_lock_a),
  .i_simulator_lock_b(i_simulator_lock_b),
  .i_protection_trip_order(i_protection_trip_order),
  .o_protection_trip_order(o_protection_trip_order),
  .i_zone_il_drive(i_zone_il_drive),
  .i_supv_drive(i_supv_drive),
  .o_zone_il(o_zone_il),
  .o_supv(o_supv),
  .o_phase_code(o_phase_code),
  .o_prot_inhibit(o_prot_inhibit),
  .o_energy_halt(o_energy_halt),
  .o_sim_active(o_sim_active),
  .o_sim_value(o_sim_value),
  .o_sim_volt_pn(o_sim_volt_pn)
);

// *** verif/test_mode_sequencer_bench.sv ***
`include "tms_defines.vh"
module test_mode_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, o_sim_value, rd;
  logic        i_simulator_lock_a, i_simulator_lock_b;
  logic        i_external_post_fault_jump, i_external_sim_trigger;
  logic [15:0] i_ia, i_ib, i_ic, o_contact, i_contact_drive;
  logic [15:0] i_contact_latched, i_contact_hold_run;
  logic [15:0] i_single_output_override_en, i_single_output_override_val;
  logic        i_protection_trip_order, o_protection_trip_order;
  logic        i_zone_il_drive, i_supv_drive, o_zone_il, o_supv;
  logic [2:0]  o_phase_code, i_sim_ch;
  logic        o_prot_inhibit, o_energy_halt, o_sim_active, o_sim_volt_pn;
  logic [19:0] o_sim_freq_mhz;
  int          fails, total_checks;
  // short ms and lockout counts keep the run brief
  tms_top #(.P_MS_CYC(4), .P_RST_MS(3), .P_LOCK_MS(5)) u_tms_top (
    .i_clk, .i_rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .i_simulator_lock_a, .i_simulator_lock_b,
    .i_external_post_fault_jump, .i_external_sim_trigger, .i_ia, .i_ib,
    .i_ic, .i_protection_trip_order, .o_protection_trip_order,
    .i_contact_drive, .i_contact_latched, .i_contact_hold_run,
    .i_single_output_override_en, .i_single_output_override_val,
    .o_contact, .i_zone_il_drive, .i_supv_drive, .o_zone_il, .o_supv,
    .o_phase_code, .o_prot_inhibit, .o_energy_halt, .o_sim_active,
    .i_sim_ch, .o_sim_value, .o_sim_volt_pn, .o_sim_freq_mhz
  );
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one apb transfer; always an idle cycle before the setup
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // bounded wait; a miss is reported as a wrong code
  task automatic wait_code(input logic [2:0] c, input int n);
    int k;
    k = 0;
    while (o_phase_code !== c && k < n) begin
      @(posedge i_clk);
      k++;
    end
    chk("phase code", {29'h0, c}, {29'h0, o_phase_code});
  endtask
  task automatic t_regs;
    apb(1'b0, `TMS_A_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    wr(`TMS_A_RATEDF, 32'd50000);
    repeat (2) @(posedge i_clk);
    chk("sim freq", 32'd50000 + 32'd50000 * `TMS_FREQ_PPM / `TMS_PPM_DEN,
        {12'h0, o_sim_freq_mhz}); // offset
    chk("volt pn", 32'h1, {31'h0, o_sim_volt_pn}); // always pn
    wr(`TMS_A_TPRE, 32'd3);
    wr(`TMS_A_TFLT, 32'd3);
    wr(`TMS_A_TPOST, 32'd3);
    wr(8'h60, 32'h5a5a0001);
    wr(8'h64, 32'h5a5a0002);
  endtask
  task automatic t_run(input logic hot);
    wr(`TMS_A_CTRL, {31'h0, hot});
    i_sim_ch <= {2'h0, hot};
    i_protection_trip_order <= 1'b1;
    wr(`TMS_A_CMD, 32'h1);
    wait_code(`TMS_PC_RST, 3); // opening reset
    wr(`TMS_A_CMD, 32'h1);
    wait_code(`TMS_PC_PRE, 20); // restart ignored
    wait_code(`TMS_PC_FLT, 20); // fault follows
    repeat (2) @(posedge i_clk);
    chk("trip out", {31'h0, hot}, {31'h0, o_protection_trip_order});
    chk("sim value", 32'h5a5a0001 + {31'h0, hot}, o_sim_value);
    wait_code(`TMS_PC_POST, 20); // post follows
    wait_code(`TMS_PC_RST, 20); // closing reset
    wait_code(`TMS_PC_NORM, 20); // back to normal
    i_protection_trip_order <= 1'b0;
  endtask
  task automatic t_jump;
    wr(`TMS_A_TFLT, 32'd60);
    wr(`TMS_A_CTRL, 32'h8);
    wr(`TMS_A_CMD, 32'h1);
    wait_code(`TMS_PC_FLT, 40);
    i_external_post_fault_jump <= 1'b1;
    wait_code(`TMS_PC_POST, 3); // jump to post
    i_external_post_fault_jump <= 1'b0;
    wait_code(`TMS_PC_NORM, 60);
    wr(`TMS_A_TFLT, 32'd3);
  endtask
  task automatic t_stop_lock;
    wr(`TMS_A_CTRL, 32'h10);
    i_simulator_lock_a <= 1'b1;
    i_external_sim_trigger <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk("locked", 32'h0, {29'h0, o_phase_code}); // trigger blocked
    i_simulator_lock_a <= 1'b0;
    i_external_sim_trigger <= 1'b0;
    @(posedge i_clk);
    i_external_sim_trigger <= 1'b1;
    wait_code(`TMS_PC_RST, 3); // trigger starts
    i_external_sim_trigger <= 1'b0;
    wait_code(`TMS_PC_PRE, 20);
    wr(`TMS_A_CMD, 32'h2);
    wait_code(`TMS_PC_NORM, 2); // stop at once
    wr(`TMS_A_CMD, 32'h1);
    wait_code(`TMS_PC_PRE, 20);
    i_simulator_lock_b <= 1'b1;
    wait_code(`TMS_PC_NORM, 3); // lock ends run
    wr(`TMS_A_CMD, 32'h1);
    repeat (4) @(posedge i_clk);
    chk("start blocked", 32'h0, {29'h0, o_phase_code}); // ignored
    i_simulator_lock_b <= 1'b0;
  endtask
  task automatic t_current;
    wr(`TMS_A_RATEDI, 32'd1000);
    wr(`TMS_A_CMD, 32'h1);
    wait_code(`TMS_PC_PRE, 20);
    i_ia <= 16'd101;
    wait_code(`TMS_PC_NORM, 3); // abort above tenth
    i_ia <= 16'd0;
    wr(`TMS_A_CMD, 32'h1);
    repeat (3) @(posedge i_clk);
    chk("lockout start", 32'h0, {29'h0, o_phase_code}); // held off
    apb(1'b0, `TMS_A_STATUS, 32'h0);
    chk("lockout flag", 32'h1, {31'h0, rd[4]}); // lockout set
    repeat (30) @(posedge i_clk);
    wr(`TMS_A_CMD, 32'h1);
    wait_code(`TMS_PC_RST, 3); // restart allowed
    wr(`TMS_A_CMD, 32'h2);
    wait_code(`TMS_PC_NORM, 3);
  endtask
  task automatic t_disarm;
    i_contact_drive <= 16'h00ff;
    i_contact_latched <= 16'h0001;
    i_contact_hold_run <= 16'h0008;
    i_zone_il_drive <= 1'b1;
    i_supv_drive <= 1'b1;
    wr(`TMS_A_DGRP, 32'h1);
    wr(`TMS_A_CTRL, 32'h2);
    wr(`TMS_A_CMD, 32'h4);
    repeat (3) @(posedge i_clk);
    i_contact_drive <= 16'hf0f0;
    i_single_output_override_en <= 16'h0012;
    repeat (3) @(posedge i_clk);
    chk("contacts", 32'hf0e6, {16'h0, o_contact}); // frozen
    chk("zone il", 32'h1, {31'h0, o_zone_il}); // never disarmed
    chk("supv", 32'h1, {31'h0, o_supv}); // never disarmed
    apb(1'b0, `TMS_A_DSTATE, 32'h0);
    chk("disarmed", 32'h0006, rd); // latched and hold wait
    i_contact_latched <= 16'h0000;
    i_contact_hold_run <= 16'h0000;
    i_single_output_override_en <= 16'h0000;
    repeat (4) @(posedge i_clk);
    chk("contacts", 32'hf0f6, {16'h0, o_contact}); // enters later
    wr(`TMS_A_CMD, 32'h8);
    wr(`TMS_A_DTIME, 32'd6);
    wr(`TMS_A_CTRL, 32'h6);
    wr(`TMS_A_CMD, 32'h4);
    repeat (4) @(posedge i_clk);
    i_contact_drive <= 16'h1234;
    repeat (3) @(posedge i_clk);
    chk("timed hold", 32'h1230, {16'h0, o_contact}); // timer runs
    repeat (40) @(posedge i_clk);
    chk("timed end", 32'h1234, {16'h0, o_contact}); // expiry
  endtask
  // a hang counts as a mismatch; the run needs under 1500 cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    fails++;
    stop_test;
  end
  initial begin
    {i_rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {i_simulator_lock_a, i_simulator_lock_b, i_protection_trip_order} = '0;
    {i_external_post_fault_jump, i_external_sim_trigger} = '0;
    {i_ia, i_ib, i_ic, i_contact_drive, i_contact_latched} = '0;
    {i_contact_hold_run, i_single_output_override_en} = '0;
    {i_single_output_override_val, i_zone_il_drive, i_supv_drive} = '0;
    i_sim_ch = 3'h0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_regs;
    t_run(1'b0);
    t_run(1'b1);
    t_jump;
    t_stop_lock;
    t_current;
    t_disarm;
    stop_test;
  end
endmodule
